// ===== src/agz_ctrl.sv
`timescale 1ns/100ps
module agz_ctrl (
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Modulator and filter
   input  wire logic        filt_valid,
   input  wire logic [23:0] filt_data,
   output logic             filt_reset,
   output logic             input_swap,
   output logic             conv_run,
   // Analog front end controls
   output logic [7:0]       mux_select,
   output logic [2:0]       analog_gain_code,
   output logic [1:0]       burnout_current,
   output logic             diode_bias_enable,
   output logic             temp_diode_route,
   // Result
   output logic             result_valid,
   output logic [23:0]      conversion_result
);
   typedef struct packed {
      logic [7:0]             input_sel;
      logic [2:0]             gain;
      logic                   offset_cancel_enable;
      logic [1:0]             burnout_sel;
      logic [1:0]             conversion_mode_select;
      logic                   scan_temp;
      logic                   start;
      agz_pkg::agz_state_t    st;
      logic [15:0]            cnt;
      logic signed [23:0]     first;
      logic [23:0]            result;
      logic                   rvalid;
      logic                   fresh;
      logic [31:0]            rdata;
      logic                   overrun;
   } agz_state_s_t;

   agz_state_s_t s_q;
   agz_state_s_t s_d;
   agz_scale_if  sif ();
   logic         temp_sel;
   logic         wr_en;
   logic         rd_en;
   logic         mapped;
   logic         cont;

   // Scaling unit, shared by both result paths
   agz_gain_shift u_scale (
      .sif (sif.unit)
   );

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign cont  = s_q.conversion_mode_select == agz_pkg::MODE_CONTINUOUS;
   assign mapped = paddr inside {agz_pkg::ADDR_INPUT_SEL, agz_pkg::ADDR_SECOND_CFG,
                                 agz_pkg::ADDR_BURNOUT, agz_pkg::ADDR_CONV_CTRL,
                                 agz_pkg::ADDR_RESULT, agz_pkg::ADDR_STATUS,
                                 agz_pkg::ADDR_SCAN_STEP};

   // Diodes count as selected from either the select field or a scan step
   assign temp_sel = (s_q.input_sel == agz_pkg::TEMP_PAIR_CODE) || s_q.scan_temp;

   // Front end drive; burnout is gated, never rewritten
   assign mux_select        = s_q.input_sel;
   assign temp_diode_route  = temp_sel;
   assign burnout_current   = temp_sel ? 2'h0 : s_q.burnout_sel;
   assign diode_bias_enable = temp_sel;
   // Analog gain saturates at sixteen; the rest is done digitally
   assign analog_gain_code  = (s_q.gain > agz_pkg::GAIN_X16) ?
                              agz_pkg::GAIN_X16 : s_q.gain;
   assign input_swap        = s_q.st == agz_pkg::ST_SWAP;
   assign conv_run          = (s_q.st == agz_pkg::ST_NORMAL) || (s_q.st == agz_pkg::ST_SWAP);
   assign filt_reset        = s_q.st == agz_pkg::ST_FLUSH;
   assign result_valid      = s_q.fresh;
   assign conversion_result = s_q.result;
   assign prdata            = s_q.rdata;
   assign pready            = 1'b1;
   assign pslverr           = psel && penable && !mapped;

   // Raw value to scale: half difference in offset-cancel mode, else plain
   always_comb begin
      sif.gain = s_q.gain;
      if (s_q.offset_cancel_enable) begin
         // One extra fraction bit holds the halving so rounding is exact
         sif.raw = 25'(signed'(s_q.first)) - 25'(signed'(filt_data));
      end else begin
         sif.raw = 25'(signed'(filt_data)) <<< 1;
      end
   end

   // Next state: register writes, read mux and conversion sequencer
   always_comb begin
      s_d       = s_q;
      s_d.fresh = 1'b0;
      s_d.start = 1'b0;
      if (wr_en) begin
         case (paddr)
            agz_pkg::ADDR_INPUT_SEL: begin
               s_d.input_sel = pwdata[7:0];
            end
            agz_pkg::ADDR_SECOND_CFG: begin
               s_d.gain = pwdata[agz_pkg::GAIN_LSB +: 3];
               s_d.offset_cancel_enable = pwdata[agz_pkg::OFFSET_CANCEL_BIT];
            end
            agz_pkg::ADDR_BURNOUT: begin
               s_d.burnout_sel = pwdata[1:0];
            end
            agz_pkg::ADDR_CONV_CTRL: begin
               s_d.conversion_mode_select = pwdata[1:0];
               s_d.start = pwdata[4];
            end
            agz_pkg::ADDR_SCAN_STEP: begin
               s_d.scan_temp = pwdata[0];
            end
            default: begin
            end
         endcase
      end
      if (psel && !penable && !pwrite) begin
         case (paddr)
            agz_pkg::ADDR_INPUT_SEL:  s_d.rdata = {24'h000000, s_q.input_sel};
            agz_pkg::ADDR_SECOND_CFG: s_d.rdata = {28'h0000000, s_q.offset_cancel_enable,
                                                   s_q.gain};
            agz_pkg::ADDR_BURNOUT:    s_d.rdata = {30'h00000000, s_q.burnout_sel};
            agz_pkg::ADDR_CONV_CTRL:  s_d.rdata = {30'h00000000, s_q.conversion_mode_select};
            agz_pkg::ADDR_RESULT:     s_d.rdata = {8'h00, s_q.result};
            agz_pkg::ADDR_STATUS:     s_d.rdata = {25'h0000000, s_q.st, s_q.overrun,
                                                   s_q.rvalid};
            agz_pkg::ADDR_SCAN_STEP:  s_d.rdata = {31'h00000000, s_q.scan_temp};
            default:                  s_d.rdata = 32'h00000000;
         endcase
      end
      // Reading the result clears ready; a new result in the same cycle wins
      if (rd_en && paddr == agz_pkg::ADDR_RESULT) begin
         s_d.rvalid = 1'b0;
      end
      case (s_q.st)
         agz_pkg::ST_IDLE: begin
            s_d.cnt = 16'h0000;
            if (s_q.start || cont) begin
               s_d.st = agz_pkg::ST_NORMAL;
            end
         end
         agz_pkg::ST_NORMAL: begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (filt_valid) begin
               s_d.cnt = 16'h0000;
               if (s_q.offset_cancel_enable) begin
                  // First half kept; swapped pass follows at once
                  s_d.first = signed'(filt_data);
                  s_d.st    = agz_pkg::ST_SWAP;
               end else begin
                  s_d.result = sif.scaled;
                  s_d.st     = agz_pkg::ST_RESULT;
               end
            end
         end
         agz_pkg::ST_SWAP: begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (filt_valid) begin
               s_d.cnt    = 16'h0000;
               s_d.result = sif.scaled;
               s_d.st     = agz_pkg::ST_RESULT;
            end
         end
         agz_pkg::ST_RESULT: begin
            s_d.overrun = s_q.rvalid;
            s_d.rvalid  = 1'b1;
            s_d.fresh   = 1'b1;
            // Continuous with offset cancel restarts as a fresh one-shot
            if (cont && s_q.offset_cancel_enable) begin
               s_d.st = agz_pkg::ST_FLUSH;
            end else if (cont) begin
               s_d.st = agz_pkg::ST_NORMAL;
            end else begin
               s_d.st = agz_pkg::ST_IDLE;
            end
         end
         agz_pkg::ST_FLUSH: begin
            // One cycle of filter reset, then straight into the next pass
            s_d.st = agz_pkg::ST_NORMAL;
         end
         default: begin
            s_d.st = agz_pkg::ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q                        <= '0;
         s_q.input_sel              <= agz_pkg::INPUT_SEL_RST;
         s_q.gain                   <= agz_pkg::GAIN_RST;
         s_q.offset_cancel_enable   <= agz_pkg::OFFSET_CANCEL_RST;
         s_q.burnout_sel            <= agz_pkg::BURNOUT_RST;
         s_q.conversion_mode_select <= agz_pkg::CONVERSION_MODE_RST;
         s_q.st                     <= agz_pkg::ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Burnout is forced off whenever the diodes are selected
   burnout_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      temp_sel |-> burnout_current == 2'h0 && diode_bias_enable)
      else $error("Burnout current on with diodes selected");

   // Diode code routes the diodes
   diode_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      mux_select == agz_pkg::TEMP_PAIR_CODE |-> temp_diode_route)
      else $error("Diode pair code not routed");

   // Bias follows selection exactly
   diode_bias_a: assert property (@(posedge pclk) disable iff (!presetn)
      !temp_sel |-> !diode_bias_enable && burnout_current == s_q.burnout_sel)
      else $error("Diode bias or burnout wrong when diodes not selected");

   // Stored burnout bits survive diode selection
   burnout_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
      (temp_sel && !(wr_en && paddr == agz_pkg::ADDR_BURNOUT)) |=> $stable(s_q.burnout_sel))
      else $error("Burnout selection changed by diode selection");

   // No swapping without offset cancel
   no_swap_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!s_q.offset_cancel_enable && s_q.st == agz_pkg::ST_NORMAL && filt_valid)
         |=> s_q.st == agz_pkg::ST_RESULT)
      else $error("Swap pass without offset cancel");

   // Two passes per result
   sequence two_pass_s;
      s_q.st == agz_pkg::ST_NORMAL && filt_valid && s_q.offset_cancel_enable;
   endsequence
   swap_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
      two_pass_s |=> input_swap && conv_run)
      else $error("Swapped pass did not follow");

   // Continuous offset cancel flushes the filter, then chains
   sequence flush_s;
      s_q.st == agz_pkg::ST_RESULT && cont && s_q.offset_cancel_enable;
   endsequence
   flush_chain_a: assert property (@(posedge pclk) disable iff (!presetn)
      flush_s |=> filt_reset ##1 (conv_run && !filt_reset))
      else $error("Filter not reset between chained results");

   // Analog gain held at sixteen for top codes
   analog_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.gain > agz_pkg::GAIN_X16 |-> analog_gain_code == agz_pkg::GAIN_X16)
      else $error("Analog gain not held at sixteen");

   // Low codes pass straight to the analog stage
   analog_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.gain <= agz_pkg::GAIN_X16 |-> analog_gain_code == s_q.gain)
      else $error("Analog gain code altered");

   // A plain pass finishing this cycle; shared by the scaling checks below
   logic plain_done;
   assign plain_done = s_q.st == agz_pkg::ST_NORMAL && filt_valid && !s_q.offset_cancel_enable;

   // Gains up to sixteen hand the filter word over untouched
   no_digital_a: assert property (@(posedge pclk) disable iff (!presetn)
      (plain_done && s_q.gain <= agz_pkg::GAIN_X16)
         |=> conversion_result == $past(filt_data))
      else $error("Digital scaling applied at low gain");

   // Code six doubles the word while the product still fits
   shift_two_a: assert property (@(posedge pclk) disable iff (!presetn)
      (plain_done && s_q.gain == agz_pkg::GAIN_X32 && filt_data[23] == filt_data[22])
         |=> conversion_result == {$past(filt_data[22:0]), 1'b0})
      else $error("Digital gain of two wrong");

   // Code seven quadruples the word while the product still fits
   shift_four_a: assert property (@(posedge pclk) disable iff (!presetn)
      (plain_done && s_q.gain == agz_pkg::GAIN_X64
       && (filt_data[23:21] == 3'h0 || filt_data[23:21] == 3'h7))
         |=> conversion_result == {$past(filt_data[21:0]), 2'h0})
      else $error("Digital gain of four wrong");

   // Large positive words saturate rather than wrap negative
   clamp_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      (plain_done && s_q.gain == agz_pkg::GAIN_X64 && !filt_data[23]
       && filt_data[22:21] != 2'h0)
         |=> conversion_result == agz_pkg::RES_MAX)
      else $error("Positive result not clamped");

   // Large negative words saturate rather than wrap positive
   clamp_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      (plain_done && s_q.gain == agz_pkg::GAIN_X64 && filt_data[23]
       && filt_data[22:21] != 2'h3)
         |=> conversion_result == agz_pkg::RES_MIN)
      else $error("Negative result not clamped");

   // Without offset cancel the filter is never reset between results
   flush_cancel_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      !s_q.offset_cancel_enable |=> !filt_reset)
      else $error("Filter reset without offset cancel");

   // Without offset cancel a swapped pass never starts
   swap_cancel_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!s_q.offset_cancel_enable && !input_swap) |=> !input_swap)
      else $error("Inputs swapped without offset cancel");

   // The first of two passes never yields a result on its own
   first_no_result_a: assert property (@(posedge pclk) disable iff (!presetn)
      two_pass_s |=> !result_valid ##1 !result_valid)
      else $error("Result after only one offset cancel pass");

   // A result is announced by exactly one cycle of valid
   sequence pulse_s;
      result_valid ##1 !result_valid;
   endsequence
   result_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.st == agz_pkg::ST_RESULT |=> pulse_s)
      else $error("Result valid not a single pulse");

   // The swapped pass ends in a result two edges later
   swap_result_a: assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.st == agz_pkg::ST_SWAP && filt_valid) |=> !result_valid ##1 pulse_s)
      else $error("No result after swapped pass");
endmodule

// ===== src/agz_pkg.sv
package agz_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_INPUT_SEL  = 8'h00;
   localparam logic [7:0] ADDR_SECOND_CFG = 8'h04;
   localparam logic [7:0] ADDR_BURNOUT    = 8'h08;
   localparam logic [7:0] ADDR_CONV_CTRL  = 8'h0c;
   localparam logic [7:0] ADDR_RESULT     = 8'h10;
   localparam logic [7:0] ADDR_STATUS     = 8'h14;
   localparam logic [7:0] ADDR_SCAN_STEP  = 8'h18;

   // Input select code that pairs the two temperature diodes
   localparam logic [7:0] TEMP_PAIR_CODE  = 8'hde;

   // Second configuration register field positions
   localparam int GAIN_LSB                = 0;
   localparam int OFFSET_CANCEL_BIT       = 3;

   // Reset values
   localparam logic [7:0]  INPUT_SEL_RST  = 8'h01;
   localparam logic [2:0]  GAIN_RST       = 3'h1;
   localparam logic        OFFSET_CANCEL_RST = 1'b0;
   localparam logic [1:0]  BURNOUT_RST    = 2'h0;
   localparam logic [1:0]  CONVERSION_MODE_RST = 2'h0;

   // Conversion mode encodings
   localparam logic [1:0]  MODE_CONTINUOUS = 2'h3;
   localparam logic [1:0]  MODE_ONE_SHOT   = 2'h2;

   // Gain codes: the two that add digital gain, and the analog cap at sixteen
   localparam logic [2:0]  GAIN_X32       = 3'h6;
   localparam logic [2:0]  GAIN_X64       = 3'h7;
   localparam logic [2:0]  GAIN_X16       = 3'h5;

   // Result width and extremes
   localparam int          RES_W          = 24;
   localparam logic [23:0] RES_MAX        = 24'h7fffff;
   localparam logic [23:0] RES_MIN        = 24'h800000;

   // Conversion time for one modulator pass
   localparam int          CONV_TIME_NS   = 10000;
   localparam int          CLK_PERIOD_NS  = 100;
   localparam logic [15:0] CONV_CYCLES    = 16'((CONV_TIME_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS);

   // Sequencer states
   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_NORMAL = 5'b00010,
      ST_SWAP   = 5'b00100,
      ST_RESULT = 5'b01000,
      ST_FLUSH  = 5'b10000
   } agz_state_t;
endpackage

// ===== src/agz_scale_if.sv
`timescale 1ns/100ps
// Scaling request from the sequencer to the digital gain stage
interface agz_scale_if;
   logic [24:0] raw;
   logic [2:0]  gain;
   logic [23:0] scaled;
   modport ctrl (output raw, output gain, input scaled);
   modport unit (input raw, input gain, output scaled);
endinterface

// ===== src/agz_gain_shift.sv
`timescale 1ns/100ps
// Digital gain stage: shift, round, then clamp
module agz_gain_shift (
   // Request and answer
   agz_scale_if.unit sif
);
   logic signed [27:0] wide;
   logic signed [27:0] rnd;
   logic signed [27:0] hi;
   logic signed [27:0] lo;

   // Shift left by one or two for the top two codes, plain pass otherwise
   always_comb begin
      wide = 28'(signed'(sif.raw));
      if (sif.gain == agz_pkg::GAIN_X32) begin
         wide = 28'(signed'(sif.raw)) <<< 1;
      end else if (sif.gain == agz_pkg::GAIN_X64) begin
         wide = 28'(signed'(sif.raw)) <<< 2;
      end
      // Raw carries one extra fraction bit from the halving; round half up
      rnd = (wide + 28'sd1) >>> 1;
      hi  = 28'(signed'(agz_pkg::RES_MAX));
      lo  = 28'(signed'(agz_pkg::RES_MIN));
      // Saturate instead of wrapping, so a large input never flips sign
      if (rnd > hi) begin
         sif.scaled = agz_pkg::RES_MAX;
      end else if (rnd < lo) begin
         sif.scaled = agz_pkg::RES_MIN;
      end else begin
         sif.scaled = rnd[23:0];
      end
   end
endmodule

// ===== verification/adc_input_gain_autozero_ctrl_tb_top.sv
`timescale 1ns/100ps
module adc_input_gain_autozero_ctrl_tb_top;
   // Bench signals, one per design port
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, mux_select;
   logic [31:0] pwdata, prdata, rd;
   logic        filt_valid, filt_reset, input_swap, conv_run;
   logic [23:0] filt_data, conversion_result;
   logic [2:0]  analog_gain_code;
   logic [1:0]  burnout_current;
   logic        diode_bias_enable, temp_diode_route, result_valid;
   int          n_fail, cmp_count, n_flush;

   agz_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .filt_valid(filt_valid), .filt_data(filt_data),
      .filt_reset(filt_reset), .input_swap(input_swap), .conv_run(conv_run),
      .mux_select(mux_select), .analog_gain_code(analog_gain_code),
      .burnout_current(burnout_current), .diode_bias_enable(diode_bias_enable),
      .temp_diode_route(temp_diode_route), .result_valid(result_valid),
      .conversion_result(conversion_result));

   // 10 MHz clock
   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   // Filter resets are counted in the background, the pulse is too short to poll
   always @(posedge pclk) if (filt_reset === 1'b1) n_flush <= n_flush + 1;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
         @(posedge pclk);
         k++;
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
      repeat (2) @(posedge pclk); // Let registered outputs follow
   endtask

   // One filter pass: wait for the matching polarity, then hand over a result
   task automatic pass(input logic [23:0] d, input logic swp);
      int k;
      k = 0;
      while (!(conv_run === 1'b1 && input_swap === swp) && k < 50) begin
         @(posedge pclk);
         k++;
      end
      check({31'h0, k < 50}, 32'h1);
      repeat (3) @(posedge pclk);
      filt_valid <= 1'b1; filt_data <= d;
      @(posedge pclk);
      filt_valid <= 1'b0; filt_data <= ~d; // Stale data is inverted, not held
   endtask

   task automatic wait_result(input logic [23:0] e);
      int k;
      k = 0;
      while (result_valid !== 1'b1 && k < 40) begin
         @(posedge pclk);
         k++;
      end
      check({31'h0, result_valid}, 32'h1);
      check({8'h0, conversion_result}, {8'h0, e});
   endtask

   // One-shot conversion; the second pass only with offset cancel on
   task automatic one_shot(input logic [3:0] cfg, input logic [23:0] a, input logic [23:0] b,
                           input logic [23:0] e);
      logic [31:0] q;
      logic        err, seen;
      seen = 1'b0;
      wr(agz_pkg::ADDR_SECOND_CFG, {28'h0, cfg});
      wr(agz_pkg::ADDR_CONV_CTRL, 32'h12);
      pass(a, 1'b0);
      if (cfg[3]) begin
         repeat (4) begin
            @(posedge pclk);
            seen = seen | (result_valid === 1'b1);
         end
         check({31'h0, seen}, 32'h0);
         pass(b, 1'b1);
      end
      wait_result(e);
      apb(1'b0, agz_pkg::ADDR_RESULT, 32'h0, q, err);
      check({8'h0, q[23:0]}, {8'h0, e});
   endtask

   // Main sequence
   initial begin
      logic [31:0] q;
      logic        err;
      n_fail = 0; cmp_count = 0; n_flush = 0;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; filt_valid = 1'b0; filt_data = 24'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and an unmapped address
      apb(1'b0, agz_pkg::ADDR_SECOND_CFG, 32'h0, q, err);
      check(q, 32'h1);
      check({31'h0, err}, 32'h0);
      check({31'h0, pready}, 32'h1);
      apb(1'b0, 8'h1c, 32'h0, q, err);
      check({31'h0, err}, 32'h1);
      check(q, 32'h0);
      $display("test reset done");
      // Diode selection by input select and by scan step
      wr(agz_pkg::ADDR_BURNOUT, 32'h3);
      wr(agz_pkg::ADDR_INPUT_SEL, 32'hde);
      check({24'h0, mux_select}, 32'hde);
      check({31'h0, temp_diode_route}, 32'h1);
      check({30'h0, burnout_current}, 32'h0);
      check({31'h0, diode_bias_enable}, 32'h1);
      apb(1'b0, agz_pkg::ADDR_BURNOUT, 32'h0, q, err);
      check({30'h0, q[1:0]}, 32'h3);
      wr(agz_pkg::ADDR_INPUT_SEL, 32'h1);
      check({30'h0, burnout_current}, 32'h3);
      check({31'h0, diode_bias_enable}, 32'h0);
      wr(agz_pkg::ADDR_SCAN_STEP, 32'h1);
      check({30'h0, burnout_current}, 32'h0);
      check({31'h0, diode_bias_enable}, 32'h1);
      wr(agz_pkg::ADDR_SCAN_STEP, 32'h0);
      check({31'h0, diode_bias_enable}, 32'h0);
      $display("test diode done");
      // Every gain code: analog part caps at x16
      for (int g = 0; g < 8; g++) begin
         wr(agz_pkg::ADDR_SECOND_CFG, g);
         check({29'h0, analog_gain_code}, (g > 5) ? 32'h5 : g);
      end
      $display("test gain codes done");
      // Plain conversions: digital shift and clamping
      one_shot(4'h0, 24'h123456, 24'h0, 24'h123456);
      one_shot(4'h5, 24'h100000, 24'h0, 24'h100000);
      one_shot(4'h6, 24'h100000, 24'h0, 24'h200000);
      one_shot(4'h7, 24'h100000, 24'h0, 24'h400000);
      one_shot(4'h7, 24'h300000, 24'h0, 24'h7fffff);
      one_shot(4'h7, 24'hc00000, 24'h0, 24'h800000);
      $display("test plain conversion done");
      // Offset cancel: half difference, digital gain, clamp
      one_shot(4'h9, 24'h000100, 24'h000040, 24'h000060);
      one_shot(4'h9, 24'h000040, 24'h000100, 24'hffffa0);
      one_shot(4'hf, 24'h000101, 24'h000100, 24'h000002);
      one_shot(4'h9, 24'h7fffff, 24'h800000, 24'h7fffff);
      check(n_flush, 32'h0);
      $display("test offset cancel done");
      // Continuous with offset cancel: chained one-shots with filter reset
      wr(agz_pkg::ADDR_SECOND_CFG, 32'h9);
      wr(agz_pkg::ADDR_CONV_CTRL, {30'h0, agz_pkg::MODE_CONTINUOUS});
      pass(24'h000200, 1'b0);
      pass(24'h000100, 1'b1);
      wait_result(24'h000080);
      pass(24'h000010, 1'b0);
      check({31'h0, n_flush > 0}, 32'h1);
      pass(24'h000030, 1'b1);
      wait_result(24'hfffff0);
      wr(agz_pkg::ADDR_CONV_CTRL, 32'h0);
      $display("test continuous done");
      complete_run();
   end

   // Watchdog, far beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      complete_run();
   end
endmodule
